/* hdl/pco_pkg.sv */
// Constants and types of the pulse credit output block
package pco_pkg;
  localparam logic [7:0] PCO_CTRL_OFS = 8'h00;
  localparam logic [7:0] PCO_TIME_OFS = 8'h04;
  localparam logic [7:0] PCO_STAT_OFS = 8'h08;
  localparam logic [7:0] PCO_FLASH_OFS = 8'h0C;
  localparam logic [1:0] PCO_VALUE_PAGE = 2'h1;
  localparam int PCO_CTRL_HOLD_BIT = 0;
  localparam int PCO_CTRL_PPU_LSB = 8;
  localparam logic [31:0] PCO_CTRL_RST = 32'h0000_0100;
  localparam logic [31:0] PCO_TIME_RST = 32'h0032_0032;
  localparam logic [7:0] PCO_VALUE_RST = 8'h01;
  localparam logic [1:0] PCO_RESP_OKAY = 2'h0;
  localparam logic [1:0] PCO_RESP_SLVERR = 2'h2;
  localparam int PCO_CLK_PERIOD_NS = 5;
  localparam int PCO_TICK_NS = 1000000;
  localparam int PCO_TICK_CYCLES = PCO_TICK_NS / PCO_CLK_PERIOD_NS;
  localparam logic [15:0] PCO_LONG_MS = 16'h0258;
  localparam logic [15:0] PCO_SHORT_MS = 16'h00C8;
  localparam logic [15:0] PCO_GAP_MS = 16'h012C;
  localparam logic [15:0] PCO_PAUSE_MS = 16'h05DC;
  localparam logic [3:0] PCO_IFACE_FLASHES = 4'h2;
  localparam logic [2:0] PCO_ERR_NONE = 3'h0;
  localparam logic [2:0] PCO_ERR_FLOAT = 3'h1;
  localparam logic [2:0] PCO_ERR_JAM = 3'h2;
  localparam logic [2:0] PCO_ERR_CHECKSUM = 3'h3;
  localparam logic [2:0] PCO_ERR_PSU = 3'h4;
  localparam int PCO_NUM_CH = 16;
  localparam int PCO_INH_LINES = 4;
  typedef enum logic [1:0] {
    PCO_ST_IDLE = 2'b00,
    PCO_ST_PAY = 2'b01,
    PCO_ST_HOLD = 2'b11,
    PCO_ST_STACK = 2'b10
  } pco_state_t;
endpackage : pco_pkg

/* hdl/pco_pulse_gen.sv */
// Pulse train generator with programmable count and on/off times
`timescale 1ns/10ps
module pco_pulse_gen
  import pco_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic tick,
  input wire logic start,
  input wire logic [15:0] total,
  input wire logic [15:0] on_ticks,
  input wire logic [15:0] off_ticks,
  output logic active,
  output logic line_on,
  output logic done
);
  logic [15:0] left;
  logic [15:0] timer;
  wire logic timer_end = (timer <= 16'h0001);
  wire logic [15:0] on_len = (on_ticks == 16'h0000) ? 16'h0001 : on_ticks;
  wire logic [15:0] off_len = (off_ticks == 16'h0000) ? 16'h0001 : off_ticks;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      active <= 1'b0;
      line_on <= 1'b0;
      done <= 1'b0;
      left <= 16'h0000;
      timer <= 16'h0000;
    end else begin
      done <= 1'b0;
      if (start && !active) begin
        // An empty train still reports completion so the caller moves on
        active <= (total != 16'h0000);
        done <= (total == 16'h0000);
        line_on <= (total != 16'h0000);
        left <= total;
        timer <= on_len;
      end else if (active && tick) begin
        if (!timer_end) begin
          timer <= timer - 16'h0001;
        end else if (line_on) begin
          line_on <= 1'b0;
          left <= left - 16'h0001;
          timer <= off_len;
        end else if (left == 16'h0000) begin
          active <= 1'b0;
          done <= 1'b1;
        end else begin
          line_on <= 1'b1;
          timer <= on_len;
        end
      end
    end
  end
endmodule : pco_pulse_gen

/* hdl/pco_flasher.sv */
// Bezel flash sequencer: a counted run of long or short flashes
`timescale 1ns/10ps
module pco_flasher
  import pco_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic tick,
  input wire logic start,
  input wire logic [3:0] count,
  input wire logic long_mode,
  output logic lamp,
  output logic active
);
  logic [3:0] left;
  logic [15:0] timer;
  logic long_q;
  wire logic [15:0] on_len = long_q ? PCO_LONG_MS : PCO_SHORT_MS;
  wire logic [15:0] off_len = (left == 4'h1) ? PCO_PAUSE_MS : PCO_GAP_MS;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lamp <= 1'b0;
      active <= 1'b0;
      left <= 4'h0;
      timer <= 16'h0000;
      long_q <= 1'b0;
    end else if (start && !active && count != 4'h0) begin
      active <= 1'b1;
      lamp <= 1'b1;
      left <= count;
      long_q <= long_mode;
      timer <= long_mode ? PCO_LONG_MS : PCO_SHORT_MS;
    end else if (active && tick) begin
      if (timer > 16'h0001) begin
        timer <= timer - 16'h0001;
      end else if (lamp) begin
        // The closing pause keeps repeated codes countable by eye
        lamp <= 1'b0;
        left <= left - 4'h1;
        timer <= off_len;
      end else if (left == 4'h0) begin
        active <= 1'b0;
      end else begin
        lamp <= 1'b1;
        timer <= on_len;
      end
    end
  end
endmodule : pco_flasher

/* hdl/pco_credit_if.sv */
// Pulse credit output interface with AXI4-Lite register access
//
// The register addresses and the AXI4-Lite slave port were decided locally.
`timescale 1ns/10ps
module pco_credit_if
  import pco_pkg::*;
#(
  parameter int TICK_CYCLES = PCO_TICK_CYCLES
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [3:0] inhibit_n,
  input wire logic escrow,
  output logic [3:0] credit_out_n,
  output logic busy_n,
  input wire logic note_valid,
  input wire logic [3:0] note_channel,
  output logic [15:0] accept_en,
  output logic note_stack,
  input wire logic cfg_double_press,
  input wire logic [2:0] err_code,
  output logic bezel_lamp
);
  localparam int TW = $clog2(TICK_CYCLES + 1);
  localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYCLES - 1);

  generate
    if (TICK_CYCLES < 1) begin : g_bad_tick
      $error("TICK_CYCLES must be at least one");
    end
  endgenerate

  pco_state_t state;
  pco_state_t next_state;
  logic [31:0] ctrl;
  logic [31:0] ptime;
  logic [7:0] value_mem [PCO_NUM_CH];
  logic [7:0] units_left;
  logic [TW-1:0] tick_cnt;
  logic tick;
  logic escrow_q;
  logic escrow_low_seen;
  logic note_stack_q;

  // Millisecond time base shared by pulse and flash timing
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tick_cnt <= '0;
      tick <= 1'b0;
    end else begin
      tick <= (tick_cnt == TICK_LAST);
      tick_cnt <= (tick_cnt == TICK_LAST) ? '0 : tick_cnt + TW'(1);
    end
  end

  // Register bus
  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  wire logic wr_go = aw_held && w_held && !s_axi_bvalid;
  wire logic rd_go = s_axi_arvalid && s_axi_arready;
  wire logic wr_value = (aw_addr[7:6] == PCO_VALUE_PAGE);
  wire logic wr_ctrl = (aw_addr == PCO_CTRL_OFS);
  wire logic wr_time = (aw_addr == PCO_TIME_OFS);
  wire logic wr_known = wr_value || wr_ctrl || wr_time;
  wire logic [3:0] wr_idx = aw_addr[5:2];

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] data,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = data[8*b +: 8];
      end
    end
    return res;
  endfunction : merge

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= PCO_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_known ? PCO_RESP_OKAY : PCO_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl <= PCO_CTRL_RST;
      ptime <= PCO_TIME_RST;
      for (int i = 0; i < PCO_NUM_CH; i++) begin
        value_mem[i] <= PCO_VALUE_RST;
      end
    end else if (wr_go) begin
      if (wr_ctrl) ctrl <= merge(ctrl, w_data, w_strb) & 32'h0000_FF01;
      if (wr_time) ptime <= merge(ptime, w_data, w_strb);
      if (wr_value && w_strb[0]) value_mem[wr_idx] <= w_data[7:0];
    end
  end

  wire logic credit_hold = ctrl[PCO_CTRL_HOLD_BIT];
  wire logic [7:0] ppu = ctrl[PCO_CTRL_PPU_LSB +: 8];
  wire logic global_inhibit = &inhibit_n;
  wire logic flash_active;
  wire logic [31:0] stat_word = {12'h000, inhibit_n, units_left,
                                 4'h0, escrow, state == PCO_ST_HOLD,
                                 global_inhibit, !busy_n};
  wire logic [31:0] flash_word = {27'h0, flash_active, err_code, bezel_lamp};
  wire logic [7:0] ar = s_axi_araddr;
  wire logic [31:0] rd_word =
    (ar[7:6] == PCO_VALUE_PAGE) ? {24'h0, value_mem[ar[5:2]]} :
    (ar == PCO_CTRL_OFS) ? ctrl :
    (ar == PCO_TIME_OFS) ? ptime :
    (ar == PCO_STAT_OFS) ? stat_word :
    (ar == PCO_FLASH_OFS) ? flash_word : 32'h0000_0000;
  wire logic rd_known = (ar[7:6] == PCO_VALUE_PAGE) || (ar == PCO_CTRL_OFS)
    || (ar == PCO_TIME_OFS) || (ar == PCO_STAT_OFS) || (ar == PCO_FLASH_OFS);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= PCO_RESP_OKAY;
    end else if (rd_go) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_known ? PCO_RESP_OKAY : PCO_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Channel gating: channels above four follow only the global inhibit
  genvar c;
  generate
    for (c = 0; c < PCO_NUM_CH; c++) begin : g_chan
      if (c < PCO_INH_LINES) begin : g_line
        assign accept_en[c] = (state == PCO_ST_IDLE) && !global_inhibit
          && !inhibit_n[c];
      end else begin : g_free
        assign accept_en[c] = (state == PCO_ST_IDLE)
          && !global_inhibit;
      end
    end
  endgenerate

  wire logic accept = note_valid && accept_en[note_channel];
  wire logic [7:0] note_units = value_mem[note_channel];
  // Low seen then high: a glitch that never went low cannot release credit
  wire logic escrow_rise = escrow && !escrow_q && escrow_low_seen;
  wire logic pay_done;
  wire logic pulse_on;
  wire logic pulse_active;
  wire logic batch_start = (state == PCO_ST_HOLD) && escrow_rise;
  wire logic [15:0] full_train = 16'(ppu * note_units);
  wire logic [15:0] train_len = (credit_hold && state == PCO_ST_HOLD)
    ? {8'h00, ppu} : full_train;
  // One start per batch: the done cycle must not launch a second train
  wire logic pay_start = (state == PCO_ST_PAY) && !pulse_active
    && !pay_done;

  always_comb begin
    next_state = state;
    unique case (state)
      PCO_ST_IDLE: begin
        if (accept) begin
          // A zero-value note has nothing to hold and goes straight on
          next_state = (credit_hold && note_units != 8'h00)
            ? PCO_ST_HOLD : PCO_ST_PAY;
        end
      end
      PCO_ST_PAY: begin
        if (pay_done) begin
          next_state = (credit_hold && units_left != 8'h00)
            ? PCO_ST_HOLD : PCO_ST_STACK;
        end
      end
      PCO_ST_HOLD: begin
        if (escrow_rise) next_state = PCO_ST_PAY;
      end
      PCO_ST_STACK: next_state = PCO_ST_IDLE;
    endcase
  end

  logic [15:0] pay_len;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= PCO_ST_IDLE;
      units_left <= 8'h00;
      pay_len <= 16'h0000;
      escrow_q <= 1'b1;
      escrow_low_seen <= 1'b0;
      note_stack_q <= 1'b0;
    end else begin
      state <= next_state;
      escrow_q <= escrow;
      note_stack_q <= (state == PCO_ST_STACK);
      if (escrow_rise) escrow_low_seen <= 1'b0;
      if (state == PCO_ST_IDLE && accept) begin
        units_left <= note_units;
        pay_len <= full_train;
        escrow_low_seen <= 1'b0;
      end else if (batch_start) begin
        units_left <= units_left - 8'h01;
        pay_len <= train_len;
      end
      // A low level in the clearing cycle still counts: the set wins
      if (!escrow) escrow_low_seen <= 1'b1;
    end
  end

  pco_pulse_gen u_pulse (
    .aclk(aclk),
    .aresetn(aresetn),
    .tick(tick),
    .start(pay_start),
    .total(pay_len),
    .on_ticks(ptime[15:0]),
    .off_ticks(ptime[31:16]),
    .active(pulse_active),
    .line_on(pulse_on),
    .done(pay_done)
  );

  assign credit_out_n = {3'b111, !pulse_on};
  assign busy_n = (state == PCO_ST_IDLE);
  assign note_stack = note_stack_q;

  // Interface code wins over a pending error code
  wire logic flash_start = cfg_double_press || (err_code != PCO_ERR_NONE);
  wire logic [3:0] flash_count = cfg_double_press ? PCO_IFACE_FLASHES
    : {1'b0, err_code};

  pco_flasher u_flash (
    .aclk(aclk),
    .aresetn(aresetn),
    .tick(tick),
    .start(flash_start),
    .count(flash_count),
    .long_mode(!cfg_double_press),
    .lamp(bezel_lamp),
    .active(flash_active)
  );

  unused_lines_a: assert property (@(posedge aclk) disable iff (!aresetn)
    credit_out_n[3:1] == 3'b111)
    else $error("unused credit lines driven");
  global_inhibit_a: assert property (@(posedge aclk) disable iff (!aresetn)
    &inhibit_n |-> accept_en == 16'h0000)
    else $error("note enabled under global inhibit");
  chan_enable_a: assert property (@(posedge aclk) disable iff (!aresetn)
    busy_n && !inhibit_n[0] |-> accept_en[0])
    else $error("channel one not enabled when pulled low");
  busy_accept_a: assert property (@(posedge aclk) disable iff (!aresetn)
    accept |=> !busy_n)
    else $error("busy not asserted after acceptance");
  held_inhibit_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !busy_n |-> accept_en == 16'h0000)
    else $error("note enabled during payout");
  hold_waits_a: assert property (@(posedge aclk) disable iff (!aresetn)
    state == PCO_ST_HOLD && !escrow_rise |=> state == PCO_ST_HOLD
    && credit_out_n[0])
    else $error("batch released without escrow toggle");
  hold_release_a: assert property (@(posedge aclk) disable iff (!aresetn)
    batch_start |=> state == PCO_ST_PAY ##0 units_left ==
    $past(units_left) - 8'h01)
    else $error("escrow toggle did not release a batch");
  stack_after_a: assert property (@(posedge aclk) disable iff (!aresetn)
    note_stack |-> $past(state) == PCO_ST_STACK && !$past(busy_n))
    else $error("note stacked outside the stack step");
  direct_pay_a: assert property (@(posedge aclk) disable iff (!aresetn)
    accept && !credit_hold |=> state == PCO_ST_PAY)
    else $error("train did not start without hold");
  iface_flash_a: assert property (@(posedge aclk) disable iff (!aresetn)
    cfg_double_press && !flash_active |=> flash_active && bezel_lamp)
    else $error("double press did not start flashing");

  hold_cycle_c: cover property (@(posedge aclk) disable iff (!aresetn)
    batch_start ##[1:1000] state == PCO_ST_HOLD);
  full_train_c: cover property (@(posedge aclk) disable iff (!aresetn)
    accept && !credit_hold ##[1:1000] note_stack);
  error_flash_c: cover property (@(posedge aclk) disable iff (!aresetn)
    err_code == PCO_ERR_JAM && !flash_active ##1 flash_active);
endmodule : pco_credit_if

/* verification/pco_host_model.sv */
// Host controller model: inhibit pull-ups, escrow toggles, pulse counter
`timescale 1ns/10ps
module pco_host_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [3:0] credit_out_n,
  input wire logic busy_n,
  output logic [3:0] inhibit_n,
  output logic escrow
);
  logic [3:0] enable_mask = 4'h0;
  logic line_q;
  int pulses;
  int stray;
  // A channel left alone reads high through its pull-up
  assign inhibit_n = ~enable_mask;
  initial escrow = 1'b1;
  always_ff @(posedge aclk) begin
    line_q <= credit_out_n[0];
    if (!aresetn) begin
      pulses <= 0;
      stray <= 0;
    end else if (line_q && !credit_out_n[0]) begin
      pulses <= pulses + 1;
      // A pulse while busy reads high would be missed by a real host
      if (busy_n) stray <= stray + 1;
    end
  end
  // Both levels are held for several cycles so the device sees each one
  task automatic toggle_escrow();
    @(posedge aclk);
    escrow <= 1'b0;
    repeat (3) @(posedge aclk);
    escrow <= 1'b1;
  endtask : toggle_escrow
endmodule : pco_host_model

/* verification/pco_credit_if_bench.sv */
// Self-checking bench for the pulse credit output interface
`timescale 1ns/10ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin fails++; \
  $display("mismatch at %0t: %h vs %h", $time, (a), (e)); end end
module pco_credit_if_bench
  import pco_pkg::*;
;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hF, note_channel = 4'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, note_valid = 1'b0;
  logic cfg_double_press = 1'b0;
  logic [2:0] err_code = 3'h0;
  logic awready, wready, bvalid, arready, rvalid, escrow, busy_n;
  logic note_stack, bezel_lamp;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [3:0] inhibit_n, credit_out_n;
  logic [15:0] accept_en;
  int fails = 0;
  int total_checks = 0;
  int base;
  int flashes;

  always #2.5 aclk = ~aclk;

  // Short tick keeps millisecond timings within a short run
  pco_credit_if #(.TICK_CYCLES(4)) pco_credit_if_inst (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .inhibit_n(inhibit_n), .escrow(escrow),
    .credit_out_n(credit_out_n), .busy_n(busy_n),
    .note_valid(note_valid), .note_channel(note_channel),
    .accept_en(accept_en), .note_stack(note_stack),
    .cfg_double_press(cfg_double_press), .err_code(err_code),
    .bezel_lamp(bezel_lamp));

  pco_host_model pco_host_model_inst (
    .aclk(aclk), .aresetn(aresetn), .credit_out_n(credit_out_n),
    .busy_n(busy_n), .inhibit_n(inhibit_n), .escrow(escrow));

  task automatic test_done();
    if (fails == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : test_done

  task automatic give_up();
    fails++;
    test_done();
  endtask : give_up

  task automatic do_reset();
    aresetn <= 1'b0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
  endtask : do_reset

  task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
                           input logic [1:0] er);
    logic aw_hs, w_hs, b_hs;
    int n;
    n = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(negedge aclk);
      aw_hs = awvalid && awready;
      w_hs = wvalid && wready;
      b_hs = bvalid;
      if (b_hs) `CHK(bresp, er)
      @(posedge aclk);
      if (aw_hs) awvalid <= 1'b0;
      if (w_hs) wvalid <= 1'b0;
      if (++n > 50) give_up();
    end while (!b_hs);
    bready <= 1'b0;
  endtask : axi_write

  task automatic axi_read(input logic [7:0] a, input logic [31:0] ed,
                          input logic [1:0] er);
    logic ar_hs, r_hs;
    int n;
    n = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge aclk);
      ar_hs = arvalid && arready;
      r_hs = rvalid;
      if (r_hs) begin `CHK(rdata, ed) `CHK(rresp, er) end
      @(posedge aclk);
      if (ar_hs) arvalid <= 1'b0;
      if (++n > 50) give_up();
    end while (!r_hs);
    rready <= 1'b0;
  endtask : axi_read

  task automatic offer(input logic [3:0] ch);
    @(posedge aclk);
    note_valid <= 1'b1;
    note_channel <= ch;
    @(posedge aclk);
    note_valid <= 1'b0;
    @(negedge aclk);
  endtask : offer

  task automatic wait_sig(ref logic s, input logic v, input int lim);
    int n;
    n = 0;
    do begin
      @(negedge aclk);
      if (++n > lim) give_up();
    end while (s !== v);
  endtask : wait_sig

  task automatic wait_pulses(input int want);
    int n;
    n = 0;
    while (pco_host_model_inst.pulses != want) begin
      @(negedge aclk);
      if (++n > 400) give_up();
    end
  endtask : wait_pulses

  task automatic count_flashes(input int cycles);
    logic prev;
    flashes = 0;
    prev = bezel_lamp;
    repeat (cycles) begin
      @(negedge aclk);
      if (bezel_lamp && !prev) flashes++;
      prev = bezel_lamp;
    end
  endtask : count_flashes

  initial begin
    do_reset();
    @(negedge aclk);
    `CHK(credit_out_n, 4'hF)
    `CHK(busy_n, 1'b1)
    `CHK(accept_en, 16'h0000)
    axi_read(PCO_CTRL_OFS, PCO_CTRL_RST, PCO_RESP_OKAY);
    axi_read(PCO_TIME_OFS, PCO_TIME_RST, PCO_RESP_OKAY);
    axi_read(8'h44, 32'h1, PCO_RESP_OKAY);
    axi_read(8'h20, 32'h0, PCO_RESP_SLVERR);
    axi_write(PCO_STAT_OFS, 32'hFFFF_FFFF, PCO_RESP_SLVERR);
    axi_write(PCO_TIME_OFS, 32'h0001_0001, PCO_RESP_OKAY);
    axi_write(8'h44, 32'h3, PCO_RESP_OKAY);
    axi_read(8'h44, 32'h3, PCO_RESP_OKAY);
    axi_write(PCO_CTRL_OFS, 32'h0000_0200, PCO_RESP_OKAY);
    for (int c = 0; c < 4; c++) begin
      @(posedge aclk);
      pco_host_model_inst.enable_mask <= 4'h1 << c;
      @(negedge aclk);
      `CHK(accept_en, 16'hFFF0 | (16'h1 << c))
    end
    offer(4'h0);
    `CHK(busy_n, 1'b1)
    // Full train with no escrow toggle: 2 pulses per unit, 3 units
    @(posedge aclk);
    pco_host_model_inst.enable_mask <= 4'h2;
    offer(4'h1);
    `CHK(busy_n, 1'b0)
    `CHK(accept_en, 16'h0000)
    wait_pulses(6);
    wait_sig(note_stack, 1'b1, 100);
    `CHK(busy_n, 1'b1)
    `CHK(credit_out_n[3:1], 3'h7)
    `CHK(pco_host_model_inst.pulses, 6)
    axi_write(PCO_CTRL_OFS, 32'h0000_0201, PCO_RESP_OKAY);
    base = pco_host_model_inst.pulses;
    offer(4'h1);
    repeat (40) @(negedge aclk);
    `CHK(pco_host_model_inst.pulses, base)
    axi_read(PCO_STAT_OFS, 32'h000D_030D, PCO_RESP_OKAY);
    for (int k = 1; k <= 3; k++) begin
      pco_host_model_inst.toggle_escrow();
      wait_pulses(base + 2 * k);
      if (k < 3) begin
        offer(4'h1);
        repeat (40) @(negedge aclk);
        `CHK(pco_host_model_inst.pulses, base + 2 * k)
        `CHK(busy_n, 1'b0)
        `CHK(accept_en, 16'h0000)
      end
    end
    wait_sig(note_stack, 1'b1, 100);
    `CHK(pco_host_model_inst.pulses, base + 6)
    `CHK(pco_host_model_inst.stray, 0)
    @(posedge aclk);
    pco_host_model_inst.enable_mask <= 4'h0;
    @(negedge aclk);
    `CHK(accept_en, 16'h0000)
    offer(4'h5);
    `CHK(busy_n, 1'b1)
    @(posedge aclk);
    cfg_double_press <= 1'b1;
    @(posedge aclk);
    cfg_double_press <= 1'b0;
    count_flashes(3000);
    `CHK(flashes, 2)
    // A fresh reset per code so each run starts from an idle flasher
    for (int c = 1; c <= 4; c++) begin
      @(posedge aclk);
      err_code <= c[2:0];
      do_reset();
      count_flashes(c * 3600 + 3000);
      `CHK(flashes, c)
    end
    test_done();
  end
endmodule : pco_credit_if_bench
